/* File: ring_queue_engine.sv */
/*
 * Device-side descriptor ring engine. Split mode polls the published
 * available index; packed mode polls descriptor flags after a kick.
 * Chain heads flow through an 8-entry FIFO to the device's processing;
 * completions come back and are written as used entries in finish order.
 * Assumes a shared-memory port that answers each request with one MEM_ACK.
 */
`timescale 1ns/100ps
`default_nettype none
module ring_queue_engine (
    input  wire logic        CLK,            // 50 MHz clock
    input  wire logic        ARST_N,         // Async reset, active low
    input  wire logic        PACKED_EN,      // Packed layout negotiated
    input  wire logic [3:0]  QSIZE_LOG2,     // Queue size exponent
    input  wire logic [15:0] AVAIL_IDX,      // Published available index
    input  wire logic        AVAIL_KICK,     // Available-buffer notification
    input  wire logic        DRV_SUPPRESS,   // Driver area: withhold used notes
    input  wire logic        CFG_NO_KICK,    // Ask driver to withhold kicks
    output logic             MEM_REQ,        // Memory request
    output logic             MEM_WE,         // Request is a write
    output logic [2:0]       MEM_AREA,       // Target area
    output logic [15:0]      MEM_SLOT,       // Slot within area
    output logic [63:0]      MEM_WDATA,      // Write word
    input  wire logic        MEM_ACK,        // Request completed
    input  wire logic [63:0] MEM_RDATA,      // Read word
    output logic             HEAD_VALID,     // Chain head offered
    input  wire logic        HEAD_READY,     // Processing takes head
    output logic [15:0]      HEAD_ID,        // Head index or buffer id
    input  wire logic        DONE_VALID,     // Buffer finished
    output logic             DONE_READY,     // Completion taken
    input  wire logic [15:0] DONE_ID,        // Finished head or buffer id
    input  wire logic [31:0] DONE_LEN,       // Bytes written
    input  wire logic        DONE_WRITTEN,   // Any data written
    output logic             USED_NOTIFY     // Used-buffer notification pulse
);
    localparam int unsigned IW = ring_queue_pkg::IDX_W;

    function automatic logic [15:0] qmask(input logic [3:0] lg);
        logic [3:0] c;
        c = (lg > ring_queue_pkg::MAX_LOG2) ? ring_queue_pkg::MAX_LOG2 : lg;
        return 16'((17'h00001 << c) - 17'h00001);
    endfunction

    // Id, length and flags share one word
    function automatic logic [63:0] pack_word(input logic [15:0] id, input logic [31:0] len,
                                              input logic [15:0] fl);
        return {id, len, fl};
    endfunction

    ring_queue_pkg::state_e state_ff;
    ring_queue_pkg::state_e nxt_state;
    logic [IW-1:0] avail_cnt_ff;
    logic [IW-1:0] nxt_avail_cnt;
    logic [IW-1:0] used_cnt_ff;
    logic [IW-1:0] nxt_used_cnt;
    logic          avail_wrap_ff;
    logic          nxt_avail_wrap;
    logic          used_wrap_ff;
    logic          nxt_used_wrap;
    logic          poll_ff;
    logic          nxt_poll;
    logic          sup_written_ff;
    logic          nxt_sup_written;
    logic          req_ff;
    logic          nxt_req;
    logic          we_ff;
    logic          nxt_we;
    logic [2:0]    area_ff;
    logic [2:0]    nxt_area;
    logic [15:0]   slot_ff;
    logic [15:0]   nxt_slot;
    logic [63:0]   wdata_ff;
    logic [63:0]   nxt_wdata;
    logic          done_rdy_ff;
    logic          nxt_done_rdy;
    logic          notify_ff;
    logic          nxt_notify;
    logic          head_vld_ff;
    logic          nxt_head_vld;
    logic [15:0]   head_id_ff;
    logic [15:0]   nxt_head_id;

    logic [15:0]   mask;
    logic          pending;
    logic          desc_ok;
    logic          push;
    logic [15:0]   push_id;
    logic          fifo_in_ready;
    logic          fifo_out_valid;
    logic          fifo_out_ready;
    logic [15:0]   fifo_out_data;
    logic [15:0]   used_fl;

    assign mask    = qmask(QSIZE_LOG2);
    assign pending = PACKED_EN ? poll_ff : (AVAIL_IDX != avail_cnt_ff);
    assign desc_ok = (MEM_RDATA[ring_queue_pkg::F_AVAIL] == avail_wrap_ff)
                  && (MEM_RDATA[ring_queue_pkg::F_USED] != avail_wrap_ff);
    // Split head index and packed buffer id share the same field
    assign push_id = MEM_RDATA[ring_queue_pkg::ID_LSB +: 16];
    // Buffer id sits in the chain's last descriptor
    assign push    = (state_ff == ring_queue_pkg::ST_FETCH) && MEM_ACK
                  && (!PACKED_EN || (desc_ok && !MEM_RDATA[ring_queue_pkg::F_NEXT]));
    assign fifo_out_ready = !head_vld_ff || HEAD_READY;

    always_comb begin
        used_fl = '0;
        used_fl[ring_queue_pkg::F_AVAIL] = used_wrap_ff;
        used_fl[ring_queue_pkg::F_USED]  = used_wrap_ff;
        used_fl[ring_queue_pkg::F_WRITE] = DONE_WRITTEN;
    end

    ring_fifo #(
        .WIDTH (16),
        .DEPTH (ring_queue_pkg::FIFO_DEPTH)
    ) u_heads (
        .clk       (CLK),
        .arst_n    (ARST_N),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (push_id),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    always_comb begin
        nxt_state       = state_ff;
        nxt_avail_cnt   = avail_cnt_ff;
        nxt_used_cnt    = used_cnt_ff;
        nxt_avail_wrap  = avail_wrap_ff;
        nxt_used_wrap   = used_wrap_ff;
        nxt_sup_written = sup_written_ff;
        nxt_req         = req_ff;
        nxt_we          = we_ff;
        nxt_area        = area_ff;
        nxt_slot        = slot_ff;
        nxt_wdata       = wdata_ff;
        nxt_notify      = 1'b0;
        // A kick in the same cycle as a failed poll keeps polling
        nxt_poll        = poll_ff;
        unique case (state_ff)
            ring_queue_pkg::ST_IDLE: begin
                if (DONE_VALID && done_rdy_ff) begin
                    // Used entry written as completion arrives
                    nxt_state = ring_queue_pkg::ST_RETIRE;
                    nxt_req   = 1'b1;
                    nxt_we    = 1'b1;
                    nxt_area  = PACKED_EN ? ring_queue_pkg::AREA_DESC : ring_queue_pkg::AREA_USED;
                    nxt_slot  = used_cnt_ff & mask;
                    nxt_wdata = pack_word(DONE_ID, DONE_LEN, PACKED_EN ? used_fl : 16'h0000);
                end else if (CFG_NO_KICK != sup_written_ff) begin
                    nxt_state = ring_queue_pkg::ST_SUPW;
                    nxt_req   = 1'b1;
                    nxt_we    = 1'b1;
                    nxt_area  = ring_queue_pkg::AREA_DEVEVT;
                    nxt_slot  = 16'h0000;
                    nxt_wdata = {63'h0, CFG_NO_KICK};
                end else if (pending && fifo_in_ready) begin
                    nxt_state = ring_queue_pkg::ST_FETCH;
                    nxt_req   = 1'b1;
                    nxt_we    = 1'b0;
                    nxt_area  = PACKED_EN ? ring_queue_pkg::AREA_DESC : ring_queue_pkg::AREA_AVAIL;
                    nxt_slot  = avail_cnt_ff & mask;
                end
            end
            ring_queue_pkg::ST_FETCH: begin
                if (MEM_ACK) begin
                    nxt_req   = 1'b0;
                    nxt_state = ring_queue_pkg::ST_IDLE;
                    if (!PACKED_EN) begin
                        nxt_avail_cnt = avail_cnt_ff + 16'h0001;
                    end else if (desc_ok) begin
                        nxt_avail_cnt = (avail_cnt_ff + 16'h0001) & mask;
                        if ((avail_cnt_ff & mask) == mask) begin
                            nxt_avail_wrap = !avail_wrap_ff;
                        end
                    end else begin
                        nxt_poll = 1'b0;
                    end
                end
            end
            ring_queue_pkg::ST_RETIRE: begin
                if (MEM_ACK) begin
                    if (PACKED_EN) begin
                        nxt_req      = 1'b0;
                        nxt_state    = ring_queue_pkg::ST_IDLE;
                        nxt_used_cnt = (used_cnt_ff + 16'h0001) & mask;
                        // Used wrap toggles after last slot
                        if ((used_cnt_ff & mask) == mask) begin
                            nxt_used_wrap = !used_wrap_ff;
                        end
                        nxt_notify = !DRV_SUPPRESS;
                    end else begin
                        nxt_state = ring_queue_pkg::ST_UIDX;
                        nxt_area  = ring_queue_pkg::AREA_USEDIDX;
                        nxt_slot  = 16'h0000;
                        nxt_wdata = {48'h0, 16'(used_cnt_ff + 16'h0001)};
                    end
                end
            end
            ring_queue_pkg::ST_UIDX: begin
                if (MEM_ACK) begin
                    nxt_req      = 1'b0;
                    nxt_state    = ring_queue_pkg::ST_IDLE;
                    nxt_used_cnt = used_cnt_ff + 16'h0001;
                    // Notify after used index is visible
                    nxt_notify   = !DRV_SUPPRESS;
                end
            end
            ring_queue_pkg::ST_SUPW: begin
                if (MEM_ACK) begin
                    nxt_req         = 1'b0;
                    nxt_state       = ring_queue_pkg::ST_IDLE;
                    nxt_sup_written = wdata_ff[0];
                end
            end
            default: begin
                nxt_state = ring_queue_pkg::ST_IDLE;
                nxt_req   = 1'b0;
            end
        endcase
        if (AVAIL_KICK) begin
            nxt_poll = 1'b1;
        end
        nxt_done_rdy = (nxt_state == ring_queue_pkg::ST_IDLE) && !(DONE_VALID && done_rdy_ff);
        nxt_head_vld = fifo_out_ready ? fifo_out_valid : head_vld_ff;
        nxt_head_id  = (fifo_out_ready && fifo_out_valid) ? fifo_out_data : head_id_ff;
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_ff       <= ring_queue_pkg::ST_IDLE;
            avail_cnt_ff   <= '0;
            used_cnt_ff    <= '0;
            avail_wrap_ff  <= ring_queue_pkg::RESET_WRAP;
            used_wrap_ff   <= ring_queue_pkg::RESET_WRAP;
            poll_ff        <= 1'b0;
            sup_written_ff <= 1'b0;
            req_ff         <= 1'b0;
            we_ff          <= 1'b0;
            area_ff        <= ring_queue_pkg::AREA_AVAIL;
            slot_ff        <= '0;
            wdata_ff       <= '0;
            done_rdy_ff    <= 1'b0;
            notify_ff      <= 1'b0;
            head_vld_ff    <= 1'b0;
            head_id_ff     <= '0;
        end else begin
            state_ff       <= nxt_state;
            avail_cnt_ff   <= nxt_avail_cnt;
            used_cnt_ff    <= nxt_used_cnt;
            avail_wrap_ff  <= nxt_avail_wrap;
            used_wrap_ff   <= nxt_used_wrap;
            poll_ff        <= nxt_poll;
            sup_written_ff <= nxt_sup_written;
            req_ff         <= nxt_req;
            we_ff          <= nxt_we;
            area_ff        <= nxt_area;
            slot_ff        <= nxt_slot;
            wdata_ff       <= nxt_wdata;
            done_rdy_ff    <= nxt_done_rdy;
            notify_ff      <= nxt_notify;
            head_vld_ff    <= nxt_head_vld;
            head_id_ff     <= nxt_head_id;
        end
    end

    assign MEM_REQ     = req_ff;
    assign MEM_WE      = we_ff;
    assign MEM_AREA    = area_ff;
    assign MEM_SLOT    = slot_ff;
    assign MEM_WDATA   = wdata_ff;
    assign DONE_READY  = done_rdy_ff;
    assign USED_NOTIFY = notify_ff;
    assign HEAD_VALID  = head_vld_ff;
    assign HEAD_ID     = head_id_ff;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    sequence s_split_retire;
        state_ff == ring_queue_pkg::ST_RETIRE && MEM_ACK && !PACKED_EN ##1 state_ff == ring_queue_pkg::ST_UIDX;
    endsequence

    // The index write is answered in a later cycle than the ring write
    sequence s_uidx_done;
        state_ff == ring_queue_pkg::ST_UIDX && MEM_ACK;
    endsequence

    a_qsize_cap: assert property (mask <= 16'h7FFF) else $error("queue mask exceeds limit");
    a_packed_cap: assert property (PACKED_EN |-> (avail_cnt_ff & ~mask) == 16'h0000)
        else $error("slot beyond ring");
    a_fetch_on_index: assert property (
        state_ff == ring_queue_pkg::ST_IDLE && !PACKED_EN && AVAIL_IDX != avail_cnt_ff
        && fifo_in_ready && !(DONE_VALID && done_rdy_ff) && CFG_NO_KICK == sup_written_ff
        |=> state_ff == ring_queue_pkg::ST_FETCH && MEM_REQ && !MEM_WE) else $error("pending head not fetched");
    a_used_flags_match: assert property (MEM_REQ && MEM_WE && MEM_AREA == ring_queue_pkg::AREA_DESC
        |-> MEM_WDATA[ring_queue_pkg::F_AVAIL] == MEM_WDATA[ring_queue_pkg::F_USED]) else $error("used flags differ");
    a_no_driver_area: assert property (MEM_REQ && MEM_WE |-> MEM_AREA != ring_queue_pkg::AREA_DRVEVT)
        else $error("wrote driver suppression area");
    a_dev_area_owner: assert property (state_ff == ring_queue_pkg::ST_SUPW
        |-> MEM_REQ && MEM_WE && MEM_AREA == ring_queue_pkg::AREA_DEVEVT) else $error("device area write malformed");
    a_done_id_order: assert property (DONE_VALID && done_rdy_ff |=> MEM_REQ && MEM_WE
        && MEM_WDATA[63:48] == $past(DONE_ID)) else $error("used entry not written for completion");
    a_split_pair: assert property (s_split_retire
        |-> MEM_REQ && MEM_WE && MEM_AREA == ring_queue_pkg::AREA_USEDIDX) else $error("used index write missing");
    a_split_notify: assert property (s_uidx_done ##0 !DRV_SUPPRESS |=> USED_NOTIFY)
        else $error("missing used notification");
    a_notify_cause: assert property (USED_NOTIFY |-> $past(MEM_ACK) && !$past(DRV_SUPPRESS)
        && ($past(state_ff) == ring_queue_pkg::ST_UIDX || $past(state_ff) == ring_queue_pkg::ST_RETIRE))
        else $error("spurious used notification");
    a_wrap_toggle: assert property (state_ff == ring_queue_pkg::ST_FETCH && MEM_ACK && PACKED_EN && desc_ok
        && (avail_cnt_ff & mask) == mask |=> avail_wrap_ff != $past(avail_wrap_ff)) else $error("wrap bit stuck");
    a_ring_order: assert property (push && PACKED_EN |-> MEM_SLOT == (avail_cnt_ff & mask))
        else $error("descriptor read out of order");
endmodule
`default_nettype wire

/* File: ring_queue_pkg.sv */
/*
 * Shared constants for the descriptor ring queue engine: memory areas,
 * descriptor field layout, flag bit positions, limits and engine states.
 * Assumes a single 50 MHz clock domain and a word-wide shared-memory port.
 */
// Behaviour
// - Device may fetch chains once it sees an advanced available index.
// - Queue size is a power of two, at most 32768 entries.
// - Device sends used notification after finishing buffers, subject to suppression.
// - Packed layout only when negotiated; at most 2^15 entries.
// - Packed queue: descriptor ring plus driver and device suppression areas.
// - Descriptors belong to buffers through their stored buffer identifier.
// - Packed device reads in order, writes used descriptor with id, notifies.
// - Device may complete out of order; used entries written in finish order.
// - Only the device writes the device suppression area.
// - Device only reads the driver suppression area.
// - Each side keeps a wrap bit starting at 1, toggled after last slot.
// - Available and used flag bits differ when available, match when used.
package ring_queue_pkg;

    localparam int unsigned IDX_W      = 16;
    localparam int unsigned LEN_W      = 32;
    localparam int unsigned WORD_W     = 64;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam logic [3:0]  MAX_LOG2   = 4'hF;

    // Word layout on the memory port: id, length, flags
    localparam int unsigned ID_LSB    = 48;
    localparam int unsigned LEN_LSB   = 16;
    localparam int unsigned FLAGS_LSB = 0;

    localparam int unsigned F_NEXT  = 0;
    localparam int unsigned F_WRITE = 1;
    localparam int unsigned F_AVAIL = 7;
    localparam int unsigned F_USED  = 15;

    localparam logic [2:0] AREA_AVAIL   = 3'h0;
    localparam logic [2:0] AREA_USED    = 3'h1;
    localparam logic [2:0] AREA_USEDIDX = 3'h2;
    localparam logic [2:0] AREA_DESC    = 3'h3;
    localparam logic [2:0] AREA_DEVEVT  = 3'h4;
    localparam logic [2:0] AREA_DRVEVT  = 3'h5;

    localparam logic RESET_WRAP = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_FETCH  = 3'h1,
        ST_RETIRE = 3'h3,
        ST_UIDX   = 3'h2,
        ST_SUPW   = 3'h6
    } state_e;

endpackage

/* File: ring_fifo.sv */
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two; single clock, async active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none
module ring_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk,       // Clock
    input  wire logic             arst_n,    // Async reset, active low
    input  wire logic             in_valid,  // Push request
    output logic                  in_ready,  // Space available
    input  wire logic [WIDTH-1:0] in_data,   // Push data
    output logic                  out_valid, // Data available
    input  wire logic             out_ready, // Pop request
    output logic [WIDTH-1:0]      out_data   // Head data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    nxt_wr;
    logic [AW-1:0]    rd_ff;
    logic [AW-1:0]    nxt_rd;
    logic [AW:0]      cnt_ff;
    logic [AW:0]      nxt_cnt;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        nxt_wr  = push ? wr_ff + AW'(1) : wr_ff;
        nxt_rd  = pop ? rd_ff + AW'(1) : rd_ff;
        nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    // Storage has no reset; only written slots are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    a_fifo_no_overflow: assert property (@(posedge clk) disable iff (!arst_n)
        !in_ready |=> cnt_ff == (AW+1)'(DEPTH) || $past(pop)) else $error("fifo count moved while full");
endmodule
`default_nettype wire

/* File: ring_mem_model.sv */
/* Shared-memory partner for the ring engine: rings and acks.
   Assumes the bench loads ring words between transfers. */
`timescale 1ns/100ps
`default_nettype none
module ring_mem_model (
    input  wire logic        clk,    // Clock
    input  wire logic        arst_n, // Reset, active low
    input  wire logic        slow,   // Answer after four cycles
    input  wire logic        req,    // Request
    input  wire logic        we,     // Write
    input  wire logic [2:0]  area,   // Area code
    input  wire logic [15:0] slot,   // Slot
    input  wire logic [63:0] wdata,  // Write word
    output logic             ack,    // Completion pulse
    output logic [63:0]      rdata   // Read word
);
    logic [15:0] avail_ring [16];
    logic [63:0] desc_ring [16];
    logic [1:0]  wait_cnt;
    logic [63:0] data_ff;
    // Outside an answer the bus shows no stale word
    assign rdata = ack ? data_ff : ~data_ff;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack <= 1'b0;
            wait_cnt <= 2'h0;
            data_ff <= 64'h0;
        end else begin
            ack <= 1'b0;
            if (req && !ack && (wait_cnt == 2'h3 || !slow)) begin
                ack <= 1'b1;
                wait_cnt <= 2'h0;
                data_ff <= (area == ring_queue_pkg::AREA_AVAIL) ? {avail_ring[slot[3:0]], 48'h0} : desc_ring[slot[3:0]];
                // a descriptor-area write lands on the same edge as its ack
                if (we && area == ring_queue_pkg::AREA_DESC) desc_ring[slot[3:0]] <= wdata;
            end else if (req && !ack) begin
                wait_cnt <= wait_cnt + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb.sv */
/* Self-checking bench for the ring engine.
   Assumes the memory partner model and a 50 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic CLK, ARST_N, PACKED_EN, AVAIL_KICK, DRV_SUPPRESS, CFG_NO_KICK, slow;
    logic MEM_REQ, MEM_WE, MEM_ACK, HEAD_VALID, HEAD_READY, DONE_VALID, DONE_READY, DONE_WRITTEN, USED_NOTIFY;
    logic [3:0]  QSIZE_LOG2;
    logic [2:0]  MEM_AREA;
    logic [15:0] AVAIL_IDX, DONE_ID, HEAD_ID, MEM_SLOT;
    logic [31:0] DONE_LEN;
    logic [63:0] MEM_WDATA, MEM_RDATA;
    logic [82:0] wr_q [$];
    int          fails = 0, total_checks = 0, notes = 0, reads = 0, drv_wr = 0;
    ring_queue_engine i_dut (.CLK(CLK), .ARST_N(ARST_N), .PACKED_EN(PACKED_EN), .QSIZE_LOG2(QSIZE_LOG2),
        .AVAIL_IDX(AVAIL_IDX), .AVAIL_KICK(AVAIL_KICK), .DRV_SUPPRESS(DRV_SUPPRESS), .CFG_NO_KICK(CFG_NO_KICK),
        .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_AREA(MEM_AREA), .MEM_SLOT(MEM_SLOT), .MEM_WDATA(MEM_WDATA),
        .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .HEAD_VALID(HEAD_VALID), .HEAD_READY(HEAD_READY),
        .HEAD_ID(HEAD_ID), .DONE_VALID(DONE_VALID), .DONE_READY(DONE_READY), .DONE_ID(DONE_ID),
        .DONE_LEN(DONE_LEN), .DONE_WRITTEN(DONE_WRITTEN), .USED_NOTIFY(USED_NOTIFY));
    ring_mem_model i_mem (.clk(CLK), .arst_n(ARST_N), .slow(slow), .req(MEM_REQ), .we(MEM_WE), .area(MEM_AREA),
        .slot(MEM_SLOT), .wdata(MEM_WDATA), .ack(MEM_ACK), .rdata(MEM_RDATA));
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        if (MEM_REQ && MEM_ACK && MEM_WE) wr_q.push_back({MEM_AREA, MEM_SLOT, MEM_WDATA});
        if (MEM_REQ && MEM_ACK && !MEM_WE) reads++;
        if (MEM_REQ && MEM_WE && MEM_AREA == ring_queue_pkg::AREA_DRVEVT) drv_wr++;
        if (USED_NOTIFY) notes++;
    end
    task automatic chk(input logic [82:0] seen, input logic [82:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic rst(input int n);
        ARST_N = 1'b0;
        repeat (n) @(negedge CLK);
        ARST_N = 1'b1;
    endtask
    task automatic get_wr(output logic [82:0] w);
        repeat (60) if (wr_q.size() == 0) @(negedge CLK);
        w = (wr_q.size() != 0) ? wr_q.pop_front() : 'x;
    endtask
    task automatic pop(input logic [15:0] exp);
        repeat (60) if (HEAD_VALID !== 1'b1) @(negedge CLK);
        chk({HEAD_VALID, HEAD_ID}, {1'b1, exp});
        HEAD_READY = 1'b1;
        @(negedge CLK);
        HEAD_READY = 1'b0;
        // An edge passes so a following call never re-raises ready in this step
        @(negedge CLK);
    endtask
    task automatic done(input logic [15:0] id, input logic [31:0] len, input logic wr);
        {DONE_ID, DONE_LEN, DONE_WRITTEN, DONE_VALID} = {id, len, wr, 1'b1};
        repeat (60) if (DONE_READY !== 1'b1) @(negedge CLK);
        @(negedge CLK);
        DONE_VALID = 1'b0;
        chk(DONE_READY, 1'b0);
    endtask
    task automatic kick;
        AVAIL_KICK = 1'b1;
        @(negedge CLK);
        AVAIL_KICK = 1'b0;
    endtask
    task automatic t_split;
        // heads written before the index moves; consumer stalls
        for (int k = 0; k < 12; k++) i_mem.avail_ring[k] = 16'h20 + k[15:0];
        AVAIL_IDX = 16'hC;
        repeat (60) @(negedge CLK);
        chk(reads < 12, 1'b1);
        for (int k = 0; k < 12; k++) pop(16'h20 + k[15:0]);
        for (int k = 12; k < 18; k++) i_mem.avail_ring[k[3:0]] = 16'h40 + k[15:0];
        AVAIL_IDX = 16'h12;
        for (int k = 12; k < 18; k++) pop(16'h40 + k[15:0]);
        $display("test split done");
    endtask
    task automatic t_used;
        logic [82:0] w;
        done(16'h2D, 32'h40, 1'b1);
        get_wr(w);
        chk(w[82:16], {3'h1, 16'h0, 16'h2D, 32'h40});
        get_wr(w);
        chk({w[82:80], w[15:0]}, {3'h2, 16'h1});
        DRV_SUPPRESS = 1'b1;
        done(16'h21, 32'h0, 1'b0);
        get_wr(w);
        chk(w[82:48], {3'h1, 16'h1, 16'h21});
        get_wr(w);
        // Notes back on, then the used index is looked at again
        DRV_SUPPRESS = 1'b0;
        chk({w[82:80], w[15:0]}, {3'h2, 16'h2});
        repeat (3) @(negedge CLK);
        chk(notes, 1);
        $display("test used done");
    endtask
    task automatic t_evt;
        logic [82:0] w;
        CFG_NO_KICK = 1'b1;
        get_wr(w);
        chk({w[82:80], w[0]}, {3'h4, 1'b1});
        CFG_NO_KICK = 1'b0;
        get_wr(w);
        chk({w[82:80], w[0]}, {3'h4, 1'b0});
        chk(drv_wr, 0);
        $display("test event area done");
    endtask
    task automatic t_packed;
        logic [82:0] w;
        rst(2);
        {PACKED_EN, slow, QSIZE_LOG2} = {1'b1, 1'b1, 4'h1};
        // two available descriptors under driver wrap 1
        i_mem.desc_ring[0] = {16'h7, 32'h100, 16'h0080};
        i_mem.desc_ring[1] = {16'h4, 32'h200, 16'h0082};
        kick();
        pop(16'h7);
        pop(16'h4);
        done(16'h4, 32'h20, 1'b1);
        get_wr(w);
        chk(w, {3'h3, 16'h0, 16'h4, 32'h20, 16'h8082});
        done(16'h7, 32'h0, 1'b0);
        get_wr(w);
        chk(w, {3'h3, 16'h1, 16'h7, 32'h0, 16'h8080});
        i_mem.desc_ring[0] = {16'h2, 32'h8, 16'h8000};
        kick();
        pop(16'h2);
        done(16'h2, 32'h8, 1'b1);
        get_wr(w);
        chk(w, {3'h3, 16'h0, 16'h2, 32'h8, 16'h0002});
        repeat (3) @(negedge CLK);
        chk(notes, 4);
        $display("test packed done");
    endtask
    initial begin
        {PACKED_EN, AVAIL_KICK, DRV_SUPPRESS, CFG_NO_KICK, HEAD_READY, DONE_VALID, DONE_WRITTEN, slow} = '0;
        {QSIZE_LOG2, AVAIL_IDX, DONE_ID, DONE_LEN} = {4'h4, 16'h0, 16'h0, 32'h0};
        rst(10);
        t_split();
        t_used();
        t_evt();
        t_packed();
        end_sim();
    end
    initial begin
        #300000;
        fails++;
        end_sim();
    end
endmodule
`default_nettype wire
